// [design/vpc_pkg.sv]
// Shared constants, types and register map of the valve profile characterizer
package vpc_pkg;
  // Clock and panel timing
  localparam int CLK_NS = 5;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * 1000 / CLK_NS;
  localparam int HOLD_MS = 3000;
  localparam int REPEAT_MS = 250;
  localparam int FLASH_MS = 500;
  localparam int BLINK_MS = 250;
  localparam int MS_W = 12;
  // Profile geometry, positions in 0.1 degree units
  localparam int N_IDX = 19;
  localparam int IDX_LAST = 18;
  localparam int POS_W = 10;
  localparam int CMD_W = 12;
  localparam int POS_FULL = 800;
  localparam logic [POS_W-1:0] POS_FINE = 10'h001;
  localparam logic [POS_W-1:0] POS_COARSE = 10'h005;
  localparam logic [POS_W:0] POS_TRAVEL = 11'h050;
  localparam logic [POS_W:0] POS_MAX = 11'h3ff;
  // Factory defaults
  localparam logic RAMP_DEF = 1'b1;
  localparam logic [3:0] LOSS_DEF = 4'h4;
  localparam logic [3:0] STBY_DEF = 4'h0;
  localparam logic [3:0] DB_DEF = 4'h2;
  localparam logic LOCK_DEF = 1'b0;
  localparam logic [15:0] PASS_DEF = 16'h0000;
  localparam logic [POS_W-1:0] HI_DEF = 10'h320;
  localparam logic [POS_W-1:0] LO_DEF = 10'h000;
  localparam logic [3:0] SETTING_MAX = 4'h9;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PASS = 8'h04;
  localparam logic [7:0] OFF_HI = 8'h08;
  localparam logic [7:0] OFF_LO = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_PROF = 8'h40;
  localparam logic [7:0] OFF_BACK = 8'h90;
  // Control register fields
  localparam int CTRL_RAMP = 0;
  localparam int CTRL_STBY = 4;
  localparam int CTRL_LOSS = 8;
  localparam int CTRL_DB = 12;
  localparam int CTRL_LOCK = 16;
  // Status register fields
  localparam int STAT_SETUP = 0;
  localparam int STAT_STBY = 1;
  localparam int STAT_CFG = 2;
  localparam int STAT_IDX = 4;
  localparam int STAT_SP = 16;
  // Adjust selector and configuration items
  localparam logic [1:0] ADJ_INDEX = 2'b00;
  localparam logic [1:0] ADJ_FINE = 2'b01;
  localparam logic [1:0] ADJ_STBY = 2'b10;
  localparam logic [2:0] CFG_LOSS = 3'h0;
  localparam logic [2:0] CFG_STBY = 3'h1;
  localparam logic [2:0] CFG_DB = 3'h2;
  localparam logic [2:0] CFG_RAMP = 3'h3;
  localparam logic [2:0] CFG_LOCK = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_CFG = 2'b10
  } vpc_state_t;

  typedef struct packed {
    logic run;
    logic setup_req;
    logic backup_req;
    logic cfg_req;
    logic [2:0] cfg_item;
    logic [1:0] fine_tune_position;
    logic nudge_up;
    logic nudge_dn;
    logic enter;
  } vpc_panel_t;

  typedef struct packed {
    logic [9:0] num;
    logic yellow;
    logic green;
  } vpc_lights_t;

  typedef struct packed {
    logic ramp;
    logic [3:0] stby;
    logic [3:0] loss;
    logic [3:0] db;
    logic lock;
    logic [15:0] pass;
    logic [POS_W-1:0] hi;
    logic [POS_W-1:0] lo;
  } vpc_cfg_t;
endpackage

// [design/vpc_top.sv]
// Valve profile characterizer: profile store, setup mode, panel and APB registers
//
// Function
// - Nineteen-index profile, linear default, two procedures
// - Ramp on: only whole indexes adjustable
// - Ramp on: half index is neighbour midpoint
// - Ramp off: every index stored independently
// - Setup command enters setup, flashes yellow/green
// - Setup index follows command, blinks its lights
// - Fine-tune push moves setpoint 0.1 degree
// - Held over 3 s: 0.5 degree repeats
// - Travel limit 8 degrees: flash, stop
// - Enter stores setpoint into selected index
// - Backup command copies profile to backup
// - Run switch leaves setup, follows command
// - Standby in setup overrides command at once
// - Standby position defaults to index 0
// - Standby held refuses every command entry
// - Standby selector ignored in run position
// - Index 0 is 0%, index 9 100%
// - Limits default 80.0 and 0.0 degrees
// - Ramp setting 1 on, 0 off, default on
// - Signal-loss default setting 4
// - Deadband default setting 2
// - Lock default off, passcode all zero
// - Rejected command flashes all numbered lights, not run
// - Config: show setting, nudge steps, enter saves
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module vpc_top #(
  parameter int P_TICK_CYCLES = vpc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Process command, 0 is 4 mA and full scale is 20 mA
  input wire logic [vpc_pkg::CMD_W-1:0] i_cmd,
  // Front panel
  input wire vpc_pkg::vpc_panel_t i_panel,
  output vpc_pkg::vpc_lights_t o_lights,
  // Valve drive
  output logic [vpc_pkg::POS_W-1:0] o_setpoint,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  import vpc_pkg::*;

  if (P_TICK_CYCLES < 2) begin : g_chk
    $error("P_TICK_CYCLES must be at least 2");
  end

  function automatic logic [4:0] idx_of(input logic [CMD_W-1:0] c);
    logic [16:0] p;
    p = {5'h00, c} * 17'h00012 + 17'h00800;
    return p[16:12];
  endfunction

  function automatic logic [9:0] leds_of(input logic [4:0] i);
    logic [9:0] l;
    l = 10'h001 << i[4:1];
    if (i[0]) begin
      l = l | (10'h002 << i[4:1]);
    end
    return l;
  endfunction

  function automatic logic [POS_W-1:0] default_pos(input int i);
    return POS_W'((i * POS_FULL + IDX_LAST / 2) / IDX_LAST);
  endfunction

  function automatic logic [POS_W-1:0] mid(input logic [POS_W-1:0] a,
                                           input logic [POS_W-1:0] b);
    logic [POS_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[POS_W:1];
  endfunction

  function automatic logic [4:0] stby_idx(input logic [3:0] s);
    logic [3:0] c;
    c = (s > SETTING_MAX) ? SETTING_MAX : s;
    return {c, 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick divider
  logic [17:0] div_cnt;
  logic tick;
  logic [17:0] next_div_cnt;
  logic next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_div_cnt = div_cnt + 18'h00001;
    if (div_cnt >= 18'(P_TICK_CYCLES - 1)) begin
      next_div_cnt = 18'h00000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      div_cnt <= 18'h00000;
      tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick <= next_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main state: mode, profile, setpoint, configuration, lights
  vpc_state_t state, next_state;
  logic [POS_W-1:0] prof [0:N_IDX-1];
  logic [POS_W-1:0] back [0:N_IDX-1];
  logic [POS_W-1:0] next_prof [0:N_IDX-1];
  logic [POS_W-1:0] next_back [0:N_IDX-1];
  vpc_cfg_t cfg, next_cfg;
  logic [4:0] sel, next_sel;
  logic [POS_W-1:0] sp, next_sp;
  logic [2:0] item, next_item;
  logic [3:0] edit, next_edit;
  logic [MS_W-1:0] hold_ms, next_hold_ms;
  logic [MS_W-1:0] rep_ms, next_rep_ms;
  logic [MS_W-1:0] flash_ms, next_flash_ms;
  logic [MS_W-1:0] blink_ms, next_blink_ms;
  logic blink, next_blink;
  logic up_q, dn_q, ent_q;
  vpc_lights_t next_lights;
  logic [POS_W-1:0] next_setpoint;

  logic up_edge, dn_edge, ent_edge, stby, any_req, apb_wr;
  logic [4:0] cmd_idx;
  logic [POS_W:0] base, hi, lo, sum;
  logic [POS_W-1:0] step;
  logic hit, reject, stored;

  assign up_edge = i_panel.nudge_up & ~up_q;
  assign dn_edge = i_panel.nudge_dn & ~dn_q;
  assign ent_edge = i_panel.enter & ~ent_q;
  assign stby = (i_panel.fine_tune_position == ADJ_STBY);
  assign any_req = i_panel.setup_req | i_panel.backup_req | i_panel.cfg_req;
  assign cmd_idx = idx_of(i_cmd);
  assign apb_wr = i_psel & i_penable & o_pready & i_pwrite;

  always_comb begin
    next_state = state;
    next_cfg = cfg;
    next_sel = sel;
    next_sp = sp;
    next_item = item;
    next_edit = edit;
    next_hold_ms = hold_ms;
    next_rep_ms = rep_ms;
    next_blink_ms = blink_ms;
    next_blink = blink;
    next_flash_ms = flash_ms;
    hit = 1'b0;
    reject = 1'b0;
    stored = 1'b0;
    step = '0;
    sum = '0;
    base = {1'b0, prof[sel]};
    hi = (base + POS_TRAVEL > POS_MAX) ? POS_MAX : base + POS_TRAVEL;
    lo = (base > POS_TRAVEL) ? base - POS_TRAVEL : '0;
    for (int i = 0; i < N_IDX; i++) begin
      next_prof[i] = prof[i];
      next_back[i] = back[i];
    end
    // Software writes to configuration
    if (apb_wr) begin
      case (i_paddr)
        OFF_CTRL: begin
          next_cfg.ramp = i_pwdata[CTRL_RAMP];
          next_cfg.stby = i_pwdata[CTRL_STBY +: 4];
          next_cfg.loss = i_pwdata[CTRL_LOSS +: 4];
          next_cfg.db = i_pwdata[CTRL_DB +: 4];
          next_cfg.lock = i_pwdata[CTRL_LOCK];
        end
        OFF_PASS: next_cfg.pass = i_pwdata[15:0];
        OFF_HI: next_cfg.hi = i_pwdata[POS_W-1:0];
        OFF_LO: next_cfg.lo = i_pwdata[POS_W-1:0];
        default: next_cfg = next_cfg;
      endcase
    end
    // Nudge hold timing; repeats start only after the hold time has passed
    if (!(i_panel.nudge_up | i_panel.nudge_dn)) begin
      next_hold_ms = '0;
      next_rep_ms = '0;
    end else if (tick) begin
      if (hold_ms <= MS_W'(HOLD_MS)) begin
        next_hold_ms = hold_ms + 1'b1;
      end
      next_rep_ms = (rep_ms == '0) ? MS_W'(REPEAT_MS - 1) : rep_ms - 1'b1;
    end
    case (state)
      ST_IDLE: begin
        if (any_req) begin
          if (i_panel.run || stby) begin
            reject = 1'b1;
          end else if (i_panel.setup_req) begin
            next_state = ST_SETUP;
            next_sel = cmd_idx;
            next_sp = prof[cmd_idx];
          end else if (i_panel.backup_req) begin
            for (int i = 0; i < N_IDX; i++) begin
              next_back[i] = prof[i];
            end
          end else begin
            next_state = ST_CFG;
            next_item = i_panel.cfg_item;
            case (i_panel.cfg_item)
              CFG_LOSS: next_edit = cfg.loss;
              CFG_STBY: next_edit = cfg.stby;
              CFG_DB: next_edit = cfg.db;
              CFG_RAMP: next_edit = {3'h0, cfg.ramp};
              CFG_LOCK: next_edit = {3'h0, cfg.lock};
              default: reject = 1'b1;
            endcase
            if (i_panel.cfg_item > CFG_LOCK) begin
              next_state = ST_IDLE;
            end
          end
        end
      end
      ST_SETUP: begin
        if (i_panel.run) begin
          next_state = ST_IDLE;
        end else if (stby) begin
          if (any_req || ent_edge) begin
            reject = 1'b1;
          end
        end else begin
          if (cmd_idx != sel) begin
            next_sel = cmd_idx;
            next_sp = prof[cmd_idx];
          end else if (i_panel.fine_tune_position == ADJ_FINE) begin
            if (up_edge || dn_edge) begin
              step = POS_FINE;
            end else if (hold_ms > MS_W'(HOLD_MS) && tick && rep_ms == '0) begin
              step = POS_COARSE;
            end
            if (i_panel.nudge_up) begin
              sum = {1'b0, sp} + {1'b0, step};
              if (step != '0 && sum >= hi) begin
                hit = 1'b1;
                next_sp = hi[POS_W-1:0];
              end else begin
                next_sp = sum[POS_W-1:0];
              end
            end else if (i_panel.nudge_dn) begin
              if (step != '0 && {1'b0, sp} <= lo + {1'b0, step}) begin
                hit = 1'b1;
                next_sp = lo[POS_W-1:0];
              end else begin
                next_sp = sp - step;
              end
            end
          end
          if (ent_edge && cmd_idx == sel) begin
            if (cfg.ramp && sel[0]) begin
              reject = 1'b1;
            end else begin
              stored = 1'b1;
              next_prof[sel] = sp;
            end
          end
          if (i_panel.backup_req) begin
            for (int i = 0; i < N_IDX; i++) begin
              next_back[i] = prof[i];
            end
          end else if (i_panel.setup_req || i_panel.cfg_req) begin
            reject = 1'b1;
          end
        end
      end
      ST_CFG: begin
        if (i_panel.run) begin
          next_state = ST_IDLE;
        end else if (stby && (any_req || ent_edge)) begin
          reject = 1'b1;
        end else if (ent_edge) begin
          next_state = ST_IDLE;
          case (item)
            CFG_LOSS: next_cfg.loss = edit;
            CFG_STBY: next_cfg.stby = edit;
            CFG_DB: next_cfg.db = edit;
            CFG_RAMP: next_cfg.ramp = edit[0];
            default: next_cfg.lock = edit[0];
          endcase
        end else if (up_edge && edit < SETTING_MAX) begin
          next_edit = edit + 1'b1;
        end else if (dn_edge && edit != 4'h0) begin
          next_edit = edit - 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Derive half indexes from the freshly stored whole neighbours only
    if (stored && cfg.ramp) begin
      for (int i = 1; i < N_IDX; i += 2) begin
        if (5'(i) + 5'h01 == sel || 5'(i) == sel + 5'h01) begin
          next_prof[i] = mid(next_prof[i-1], next_prof[i+1]);
        end
      end
    end
    // Blink and error flash timers
    if (tick) begin
      if (blink_ms == '0) begin
        next_blink_ms = MS_W'(BLINK_MS - 1);
        next_blink = ~blink;
      end else begin
        next_blink_ms = blink_ms - 1'b1;
      end
      if (flash_ms != '0) begin
        next_flash_ms = flash_ms - 1'b1;
      end
    end
    if (reject || hit) begin
      next_flash_ms = MS_W'(FLASH_MS);
    end
    // Valve setpoint; standby only counts in setup, never in run
    if (state == ST_SETUP && !i_panel.run) begin
      next_setpoint = stby ? prof[stby_idx(cfg.stby)] : sp;
    end else begin
      next_setpoint = prof[cmd_idx];
    end
    // Lights
    next_lights.num = leds_of(cmd_idx);
    next_lights.yellow = 1'b0;
    next_lights.green = i_panel.run;
    if (state == ST_SETUP) begin
      next_lights.num = blink ? leds_of(sel) : 10'h000;
      next_lights.yellow = blink;
      next_lights.green = blink;
    end else if (state == ST_CFG) begin
      next_lights.num = 10'h001 << edit;
    end
    if (flash_ms != '0) begin
      next_lights.num = 10'h3ff;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      for (int i = 0; i < N_IDX; i++) begin
        prof[i] <= default_pos(i);
        back[i] <= default_pos(i);
      end
      cfg.ramp <= RAMP_DEF;
      cfg.stby <= STBY_DEF;
      cfg.loss <= LOSS_DEF;
      cfg.db <= DB_DEF;
      cfg.lock <= LOCK_DEF;
      cfg.pass <= PASS_DEF;
      cfg.hi <= HI_DEF;
      cfg.lo <= LO_DEF;
      sel <= 5'h00;
      sp <= '0;
      item <= 3'h0;
      edit <= 4'h0;
      hold_ms <= '0;
      rep_ms <= '0;
      flash_ms <= '0;
      blink_ms <= '0;
      blink <= 1'b0;
      up_q <= 1'b0;
      dn_q <= 1'b0;
      ent_q <= 1'b0;
      o_lights <= '0;
      o_setpoint <= '0;
    end else begin
      state <= next_state;
      for (int i = 0; i < N_IDX; i++) begin
        prof[i] <= next_prof[i];
        back[i] <= next_back[i];
      end
      cfg <= next_cfg;
      sel <= next_sel;
      sp <= next_sp;
      item <= next_item;
      edit <= next_edit;
      hold_ms <= next_hold_ms;
      rep_ms <= next_rep_ms;
      flash_ms <= next_flash_ms;
      blink_ms <= next_blink_ms;
      blink <= next_blink;
      up_q <= i_panel.nudge_up;
      dn_q <= i_panel.nudge_dn;
      ent_q <= i_panel.enter;
      o_lights <= next_lights;
      o_setpoint <= next_setpoint;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state so read data comes from a flip-flop
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [7:0] poff;

  always_comb begin
    next_pready = 1'b0;
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    poff = 8'h00;
    if (i_psel && i_penable && !o_pready) begin
      next_pready = 1'b1;
      case (i_paddr)
        OFF_CTRL: begin
          next_prdata[CTRL_RAMP] = cfg.ramp;
          next_prdata[CTRL_STBY +: 4] = cfg.stby;
          next_prdata[CTRL_LOSS +: 4] = cfg.loss;
          next_prdata[CTRL_DB +: 4] = cfg.db;
          next_prdata[CTRL_LOCK] = cfg.lock;
        end
        OFF_PASS: next_prdata[15:0] = cfg.pass;
        OFF_HI: next_prdata[POS_W-1:0] = cfg.hi;
        OFF_LO: next_prdata[POS_W-1:0] = cfg.lo;
        OFF_STAT: begin
          next_prdata[STAT_SETUP] = (state == ST_SETUP);
          next_prdata[STAT_STBY] = (state == ST_SETUP) && stby && !i_panel.run;
          next_prdata[STAT_CFG] = (state == ST_CFG);
          next_prdata[STAT_IDX +: 5] = sel;
          next_prdata[STAT_SP +: POS_W] = o_setpoint;
          next_pslverr = i_pwrite;
        end
        default: begin
          next_pslverr = 1'b1;
          if (i_paddr[1:0] == 2'b00 && i_paddr >= OFF_PROF &&
              i_paddr < OFF_PROF + 8'(4 * N_IDX)) begin
            poff = (i_paddr - OFF_PROF) >> 2;
            next_prdata[POS_W-1:0] = prof[poff[4:0]];
            next_pslverr = i_pwrite;
          end else if (i_paddr[1:0] == 2'b00 && i_paddr >= OFF_BACK &&
                       i_paddr < OFF_BACK + 8'(4 * N_IDX)) begin
            poff = (i_paddr - OFF_BACK) >> 2;
            next_prdata[POS_W-1:0] = back[poff[4:0]];
            next_pslverr = i_pwrite;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= next_pready;
      o_prdata <= next_prdata;
      o_pslverr <= next_pslverr;
    end
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the valve profile characterizer
`timescale 1ns/1ps
module tb_top;
  import vpc_pkg::*;
  logic i_clock = 1'b0;
  logic i_sys_rst;
  logic [CMD_W-1:0] cmd;
  vpc_panel_t panel;
  vpc_lights_t lights;
  logic [POS_W-1:0] sp;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [32:0] exp_q[$];
  logic [9:0] prof[N_IDX];
  int num_errors = 0;
  int check_count = 0;
  always #2.5 i_clock = ~i_clock;
  vpc_panel_model pm (.i_clock(i_clock), .o_cmd(cmd), .o_panel(panel));
  vpc_top #(.P_TICK_CYCLES(10)) dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cmd(cmd),
    .i_panel(panel), .o_lights(lights), .o_setpoint(sp), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Answers are compared in order against the notes left by the master
  always @(posedge i_clock) begin
    if (psel && penable && pready) begin
      chk({31'h0, pslverr}, {31'h0, exp_q[0][32]});
      if (!pwrite) begin
        chk(prdata, exp_q[0][31:0]);
      end
      void'(exp_q.pop_front());
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // Flash of all numbered lights must show within lim cycles
  task automatic wait_flash(input int lim);
    int n;
    n = 0;
    while (lights.num !== 10'h3ff && n < lim) begin
      @(posedge i_clock);
      n++;
    end
    chk(32'(n < lim), 32'h1);
  endtask
  function automatic logic [31:0] ctrl(input logic [3:0] db);
    return {15'h0, 1'b0, db, 4'h4, 4'h0, 3'h0, 1'b1};
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    // The longest test holds a nudge for 72000 cycles; the whole run is about 88000
    repeat (100000) @(posedge i_clock);
    num_errors++;
    end_sim();
  end
  initial begin
    int r;
    i_sys_rst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    void'($urandom(32'hce28));
    for (int i = 0; i < N_IDX; i++) prof[i] = 10'((i * 1600 + 18) / 36);
    repeat (4) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rd(OFF_CTRL, ctrl(4'h2));
    rd(OFF_PASS, 32'h0);
    rd(OFF_HI, 32'h320);
    rd(OFF_LO, 32'h0);
    for (int i = 0; i < N_IDX; i++) begin
      rd(OFF_PROF + 8'(4 * i), 32'(prof[i]));
      rd(OFF_BACK + 8'(4 * i), 32'(prof[i]));
    end
    pm.set_cmd(12'hfff);
    cyc(5);
    chk(32'(sp), 32'h320);
    $display("defaults done");
    r = $urandom % 9;
    apb(1'b1, OFF_CTRL, ctrl(4'(r)), 33'h0);
    rd(OFF_CTRL, ctrl(4'(r)));
    apb(1'b1, OFF_STAT, $urandom, {1'b1, 32'h0});
    apb(1'b1, OFF_PROF, $urandom, {1'b1, 32'h0});
    rd(OFF_PROF, 32'(prof[0]));
    apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
    $display("register access done");
    pm.set_sw(1'b0, ADJ_FINE);
    pm.pulse(2, CFG_DB);
    chk(32'(lights.num), 32'h1 << r);
    pm.push(0, 2);
    chk(32'(lights.num), 32'h1 << (r + 1));
    pm.push(2, 2);
    rd(OFF_CTRL, ctrl(4'(r + 1)));
    pm.pulse(2, 3'h5);
    wait_flash(3000);
    rd(OFF_CTRL, ctrl(4'(r + 1)));
    cyc(5000);
    $display("config done");
    pm.set_cmd(12'd455);
    pm.pulse(0, 3'h0);
    rd(OFF_STAT, (32'(prof[2]) << 16) | 32'h21);
    for (int i = 0; i < 3; i++) pm.push(0, 2);
    cyc(2);
    chk(32'(sp), 32'(prof[2]) + 32'd3);
    pm.push(2, 2);
    prof[2] = prof[2] + 10'd3;
    prof[1] = 10'((11'(prof[0]) + 11'(prof[2])) >> 1);
    prof[3] = 10'((11'(prof[2]) + 11'(prof[4])) >> 1);
    for (int i = 1; i < 4; i++) rd(OFF_PROF + 8'(4 * i), 32'(prof[i]));
    fork
      pm.push(0, 72000);
      wait_flash(72000);
    join
    chk(32'(sp), 32'(prof[2]) + 32'd80);
    cyc(5000);
    pm.set_cmd(12'd228);
    cyc(4);
    pm.push(2, 2);
    wait_flash(3000);
    rd(OFF_PROF + 8'h04, 32'(prof[1]));
    $display("setup done");
    pm.set_cmd(12'd455);
    pm.set_sw(1'b0, ADJ_STBY);
    cyc(4);
    chk(32'(sp), 32'(prof[0]));
    pm.push(0, 2);
    pm.push(2, 2);
    chk(32'(sp), 32'(prof[0]));
    rd(OFF_STAT, (32'(prof[0]) << 16) | 32'h23);
    cyc(5000);
    pm.set_sw(1'b1, ADJ_STBY);
    cyc(4);
    chk(32'(sp), 32'(prof[2]));
    chk(32'(lights.num), 32'h2);
    pm.set_cmd(12'd228);
    cyc(4);
    chk(32'(lights.num), 32'h3);
    pm.set_sw(1'b0, ADJ_FINE);
    pm.pulse(1, 3'h0);
    for (int i = 1; i < 4; i++) rd(OFF_BACK + 8'(4 * i), 32'(prof[i]));
    $display("standby and backup done");
    // Ramp off: an odd index takes enter and its neighbours stay as they were
    apb(1'b1, OFF_CTRL, ctrl(4'h2) ^ 32'h1, 33'h0);
    pm.pulse(0, 3'h0);
    pm.push(0, 2);
    pm.push(2, 2);
    prof[1] = prof[1] + 10'd1;
    for (int i = 0; i < 3; i++) rd(OFF_PROF + 8'(4 * i), 32'(prof[i]));
    $display("ramp off done");
    end_sim();
  end
endmodule

// [tb/vpc_panel_model.sv]
// Process controller and front panel model driving the characterizer
`timescale 1ns/1ps
module vpc_panel_model (
  // Clock
  input wire logic i_clock,
  // Command and panel switches
  output logic [vpc_pkg::CMD_W-1:0] o_cmd,
  output vpc_pkg::vpc_panel_t o_panel
);
  import vpc_pkg::*;
  initial begin
    o_cmd = '0;
    o_panel = '0;
    o_panel.run = 1'b1;
    o_panel.fine_tune_position = ADJ_FINE;
  end
  // Controller output; 0 and full scale are the characterisation extremes
  task automatic set_cmd(input logic [CMD_W-1:0] c);
    @(posedge i_clock);
    o_cmd <= c;
  endtask
  task automatic set_sw(input logic run, input logic [1:0] fine_tune_position);
    @(posedge i_clock);
    o_panel.run <= run;
    o_panel.fine_tune_position <= fine_tune_position;
  endtask
  // Decoded commands arrive as one-cycle pulses: 0 setup, 1 backup, 2 config
  task automatic pulse(input int n, input logic [2:0] item);
    @(posedge i_clock);
    o_panel.cfg_item <= item;
    o_panel.setup_req <= (n == 0);
    o_panel.backup_req <= (n == 1);
    o_panel.cfg_req <= (n == 2);
    @(posedge i_clock);
    o_panel.setup_req <= 1'b0;
    o_panel.backup_req <= 1'b0;
    o_panel.cfg_req <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask
  // Button held len cycles: 0 up, 1 down, 2 enter; a gap keeps edges distinct
  task automatic push(input int n, input int len);
    @(posedge i_clock);
    o_panel.nudge_up <= (n == 0);
    o_panel.nudge_dn <= (n == 1);
    o_panel.enter <= (n == 2);
    repeat (len) @(posedge i_clock);
    o_panel.nudge_up <= 1'b0;
    o_panel.nudge_dn <= 1'b0;
    o_panel.enter <= 1'b0;
    repeat (4) @(posedge i_clock);
  endtask
endmodule

// [tb/vpc_top_assertions.sv]
// Port-level assertions for the valve profile characterizer
`timescale 1ns/1ps
module vpc_top_assertions #(
  parameter int P_TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Command and panel
  input wire logic [vpc_pkg::CMD_W-1:0] i_cmd,
  input wire vpc_pkg::vpc_panel_t i_panel,
  input wire vpc_pkg::vpc_lights_t o_lights,
  input wire logic [vpc_pkg::POS_W-1:0] o_setpoint,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr
);
  import vpc_pkg::*;
  logic in_setup;
  logic next_in_setup;
  ////////////////////////////////////////////////////////////
  // Setup mode tracked from the panel only; lock paths are out of scope
  always_comb begin
    next_in_setup = in_setup;
    if (i_sys_rst || i_panel.run) begin
      next_in_setup = 1'b0;
    end else if (i_panel.setup_req && i_panel.fine_tune_position != ADJ_STBY) begin
      next_in_setup = 1'b1;
    end
  end
  always_ff @(posedge i_clock) begin
    in_setup <= next_in_setup;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////
  pready_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready late");
  pready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  unmapped_err_a: assert property (i_psel && i_penable && !o_pready && i_paddr == 8'h20
    |=> o_pslverr && o_prdata == 32'h0) else $error("unmapped answer");
  reset_quiet_a: assert property (disable iff (1'b0) i_sys_rst
    |=> o_setpoint == 10'h000 && o_lights == '0 && !o_pready) else $error("reset outputs");
  run_green_a: assert property (i_panel.run [*3] |=> o_lights.green)
    else $error("green off in run");
  setup_flash_a: assert property (in_setup [*3] |-> o_lights.yellow == o_lights.green)
    else $error("setup lights apart");
  standby_hold_a: assert property ((in_setup && i_panel.fine_tune_position == ADJ_STBY) [*4]
    |-> $stable(o_setpoint)) else $error("standby moved");
  idx_zero_a: assert property ((i_panel.run && i_cmd == 12'h000) [*3]
    |=> o_lights.num inside {10'h001, 10'h3ff}) else $error("index 0 lights");
  full_scale_a: assert property ((i_panel.run && i_cmd == 12'hfff) [*3]
    |=> o_setpoint == 10'h320) else $error("full scale");
endmodule
bind vpc_top vpc_top_assertions #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cmd(i_cmd), .i_panel(i_panel),
  .o_lights(o_lights), .o_setpoint(o_setpoint), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr));
